// ===== dv/dimf_link_ctrl.sv
/*
 * Link controller model: issues command strobes and block headers.
 * Assumes the bench calls its tasks from one process only.
 */
`timescale 1ns/1ps
module dimf_link_ctrl
	import dimf_pkg::*;
(
	input  wire logic   clk_sys,
	output dimf_cmd_t   cmd,
	output logic        blk_valid,
	output logic [15:0] blk_addr,
	output logic [15:0] blk_data,
	output logic        blk_write
);
	// Idle link at time zero
	initial begin
		cmd = '0;
		blk_valid = 1'b0;
		blk_addr = 16'h0000;
		blk_data = 16'h0000;
		blk_write = 1'b0;
	end

	// One header per call; lines inverted after release so stale values never match
	task automatic blk(input logic [15:0] a, input logic [15:0] d, input logic w);
		@(posedge clk_sys);
		blk_valid <= 1'b1;
		blk_addr  <= a;
		blk_data  <= d;
		blk_write <= w;
		@(posedge clk_sys);
		blk_valid <= 1'b0;
		blk_addr  <= ~a;
		blk_data  <= ~d;
		blk_write <= ~w;
	endtask

	// One-cycle command strobe
	task automatic send(input dimf_cmd_t c);
		@(posedge clk_sys);
		cmd <= c;
		@(posedge clk_sys);
		cmd <= '0;
	endtask
endmodule

// ===== dv/tb_top.sv
/*
 * Self-checking bench for the mode controller.
 * Assumes the link model drives commands and blocks; bench drives levels.
 */
`timescale 1ns/1ps
module tb_top
	import dimf_pkg::*;
;
	logic        clk_sys, reset, spill_pin, busy;
	dimf_cond_t  cond;
	dimf_cmd_t   cmd;
	logic        blk_valid, blk_write, cfg_wr, cfg_alt, cmd_exec;
	logic [15:0] blk_addr, blk_data, cfg_data, cmd_addr;
	dimf_mode_t  mode;
	logic        spill_warning_control, detector_power, chip_autonomous;
	logic        busy_reject_flag, unknown_flag, refused_flag;
	logic [1:0]  cfg_slab;
	logic [11:0] cfg_word;
	int          fails, check_count, i;
	logic [15:0] bad [4] = '{16'h0091, 16'h0fff, 16'h9000, 16'hffff};

	dimf_link_ctrl dimf_link_ctrl_inst (.clk_sys, .cmd, .blk_valid, .blk_addr,
		.blk_data, .blk_write);
	// Short spill hold keeps the run brief
	dimf_mode_fsm #(.SPILL_LEN(3)) dimf_mode_fsm_inst (.clk_sys, .reset, .cmd,
		.cond, .spill_pin, .blk_valid, .blk_addr, .blk_data, .blk_write, .busy,
		.mode, .spill_warning_control, .detector_power, .chip_autonomous, .cfg_wr,
		.cfg_slab, .cfg_alt, .cfg_word, .cfg_data, .cmd_exec, .cmd_addr,
		.busy_reject_flag, .unknown_flag, .refused_flag);

	// 250 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Command, then mode one cycle later
	task automatic go(input logic [7:0] c, input dimf_mode_t m);
		dimf_link_ctrl_inst.send(dimf_cmd_t'(c));
		#1 chk(16'(mode), 16'(m));
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		dimf_link_ctrl_inst.blk(a, d, 1'b1);
		#1;
	endtask

	// Main sequence; cmd bits: 80 power, 40 regs off, 20 mode, 10 pulse,
	// 08 start, 04 stop, 02 fetch, 01 reset
	initial begin
		fails = 0;
		check_count = 0;
		reset = 1'b1;
		spill_pin = 1'b0;
		busy = 1'b0;
		cond = '0;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 chk({15'h0, detector_power}, 16'h0000);
		go(8'h08, DIMF_SLEEP);
		wr(16'h1003, 16'h00a5);
		chk({cfg_wr, 1'b0, cfg_slab, cfg_word}, 16'h8003);
		go(8'h80, DIMF_READY);
		go(8'h08, DIMF_READY);
		for (i = 0; i < 8; i++) begin
			wr({4'(i + 1), 12'hfff}, 16'(i));
			chk({cfg_wr, cfg_alt, cfg_slab, cfg_word}, {1'b1, 1'(i % 2), 2'(i / 2), 12'hfff});
		end
		wr(16'h0090, 16'h0000);
		chk({cmd_exec, cmd_addr[14:0]}, 16'h8090);
		for (i = 0; i < 4; i++) begin
			wr(bad[i], 16'h5a5a);
			chk({unknown_flag, cfg_wr, cmd_exec, cfg_data[12:0]}, 16'h8007);
		end
		@(posedge clk_sys) busy <= 1'b1;
		wr(16'h1000, 16'h1111);
		chk({14'h0, busy_reject_flag, cfg_wr}, 16'h0002);
		@(posedge clk_sys) busy <= 1'b0;
		cond <= 5'b11000;
		go(8'h08, DIMF_READY);
		// Spill warning while start is barred: bit must time out on its own
		wr(SPILL_ADDR, SPILL_SET_VAL);
		chk({spill_warning_control, detector_power, 12'h0, mode}, 16'hc001);
		repeat (3) @(posedge clk_sys);
		#1 chk({15'h0, spill_warning_control}, 16'h0001);
		@(posedge clk_sys);
		#1 chk({15'h0, spill_warning_control}, 16'h0000);
		@(posedge clk_sys) cond <= 5'b10000;
		wr(SPILL_ADDR, SPILL_SET_VAL);
		chk({spill_warning_control, cmd_exec, chip_autonomous, 11'h0, mode}, 16'he002);
		@(posedge clk_sys);
		#1 chk({15'h0, spill_warning_control}, 16'h0000);
		wr(16'h2000, 16'h2222);
		chk({refused_flag, cfg_wr, cfg_data[13:0]}, 16'h8007);
		// Every way back to ready; start alternates acquisition and fetch
		for (i = 0; i < 5; i++) begin
			if (i > 0)
				go((i % 2) ? 8'h02 : 8'h08, DIMF_OPER);
			if (i < 2)
				go(i ? 8'h01 : 8'h04, DIMF_READY);
			else begin
				@(posedge clk_sys) cond <= 5'b10000 | (5'b00100 >> (i - 2));
				@(posedge clk_sys);
				#1 chk(16'(mode), 16'(DIMF_READY));
				@(posedge clk_sys) cond <= 5'b10000;
			end
		end
		go(8'hc0, DIMF_SLEEP);
		go(8'h20, DIMF_READY);
		go(8'h20, DIMF_SLEEP);
		go(8'h10, DIMF_READY);
		go(8'h10, DIMF_SLEEP);
		// Pin passes a synchroniser, so allow a few cycles
		@(posedge clk_sys) spill_pin <= 1'b1;
		for (i = 0; i < 8 && mode !== DIMF_READY; i++) begin
			@(posedge clk_sys);
			#1;
		end
		chk(16'(mode), 16'(DIMF_READY));
		give_verdict;
	end
endmodule

// ===== logic/dimf_addr_decode.sv
/*
 * Address decoder for the command address field of block transfers.
 * Assumes the address is stable in the cycle the block header is valid.
 */
`timescale 1ns/1ps
module dimf_addr_decode
	import dimf_pkg::*;
(
	input  wire logic [15:0] addr,
	output dimf_addr_t       kind,
	output logic [1:0]       slab,
	output logic             alt_set,
	output logic [11:0]      word
);
	// Slab windows pair default/alternative: slab = (top nibble - 1) / 2
	logic [3:0] nib;
	logic [3:0] nib_m1;
	assign nib    = addr[15:12];
	assign nib_m1 = nib - 4'h1;
	assign slab    = nib_m1[2:1];        // [R3] [R4]
	assign alt_set = nib_m1[0];          // [R4] Even top nibble is the alternative set
	assign word    = addr[11:0];

	always_comb begin
		if (addr <= CMD_LAST) begin
			kind = DIMF_ADDR_CMD;        // [R2]
		end else if (addr >= SLAB_BASE && addr <= SLAB_LAST) begin
			kind = DIMF_ADDR_SLAB;       // [R3] [R4]
		end else begin
			kind = DIMF_ADDR_UNKNOWN;    // [R17]
		end
	end
endmodule

// ===== logic/dimf_mode_fsm.sv
/*
 * Top-level mode controller: three-state machine, spill-warning register,
 * block transfer address classification and command acceptance.
 * Assumes command strobes and block headers arrive synchronous to clk_sys;
 * only the asynchronous spill warning pin is synchronised here.
 */
`timescale 1ns/1ps
module dimf_mode_fsm
	import dimf_pkg::*;
#(
	parameter int SPILL_LEN = SPILL_CYCLES
)(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire dimf_cmd_t   cmd,
	input  wire dimf_cond_t  cond,
	input  wire logic        spill_pin,
	input  wire logic        blk_valid,
	input  wire logic [15:0] blk_addr,
	input  wire logic [15:0] blk_data,
	input  wire logic        blk_write,
	input  wire logic        busy,
	output dimf_mode_t       mode,
	output logic             spill_warning_control,
	output logic             detector_power,
	output logic             chip_autonomous,
	output logic             cfg_wr,
	output logic [1:0]       cfg_slab,
	output logic             cfg_alt,
	output logic [11:0]      cfg_word,
	output logic [15:0]      cfg_data,
	output logic             cmd_exec,
	output logic [15:0]      cmd_addr,
	output logic             busy_reject_flag,
	output logic             unknown_flag,
	output logic             refused_flag
);
	typedef struct packed {
		dimf_mode_t  mode;
		logic        spill;
		logic [7:0]  spill_cnt;
		logic        sync1;
		logic        sync2;
		logic        sync3;
		logic        cfg_wr;
		logic [1:0]  cfg_slab;
		logic        cfg_alt;
		logic [11:0] cfg_word;
		logic [15:0] cfg_data;
		logic        cmd_exec;
		logic [15:0] cmd_addr;
		logic        busy_rej;
		logic        unknown;
		logic        refused;
	} dimf_state_t;

	dimf_state_t st;
	dimf_state_t next_st;

	dimf_addr_t  kind;
	logic [1:0]  dec_slab;
	logic        dec_alt;
	logic [11:0] dec_word;

	dimf_addr_decode dimf_addr_decode_inst (
		.addr    (blk_addr),
		.kind    (kind),
		.slab    (dec_slab),
		.alt_set (dec_alt),
		.word    (dec_word)
	);

	logic spill_async;
	logic spill_wr;
	logic to_ready;
	logic to_sleep;
	logic start_req;
	logic stop_req;
	logic allowed;

	// Synchronised rising edge of the spill pin; reads second and third stage only
	assign spill_async = st.sync2 & ~st.sync3;
	assign spill_wr    = blk_valid & blk_write & ~busy & (blk_addr == SPILL_ADDR)
		& (blk_data == SPILL_SET_VAL);
	assign allowed     = cond.config_done & ~cond.error_pending;
	assign to_ready    = cmd.power_on & ~cmd.regs_off | spill_async
		| cmd.mode_select_cmd | cmd.pulse_dbg;                           // [R10]
	assign to_sleep    = cmd.power_on & cmd.regs_off | cmd.mode_select_cmd
		| cmd.pulse_dbg;                                                   // [R11]
	assign start_req   = cmd.acq_start | spill_wr | cmd.results_fetch;     // [R13]
	assign stop_req    = cmd.acq_stop | cond.buffer_full_flag
		| cond.analog_memory_saturated | cond.readout_done | cmd.reset_cmd;  // [R14]

	// Next state of everything; flags are one-cycle pulses per block
	always_comb begin
		next_st          = st;
		next_st.sync1    = spill_pin;
		next_st.sync2    = st.sync1;
		next_st.sync3    = st.sync2;
		next_st.cfg_wr   = 1'b0;
		next_st.cmd_exec = 1'b0;
		next_st.busy_rej = 1'b0;
		next_st.unknown  = 1'b0;
		next_st.refused  = 1'b0;

		// Mode machine; sleep holds until a wake trigger [R18]
		case (st.mode)
			DIMF_SLEEP: begin
				if (to_ready) begin
					next_st.mode = DIMF_READY;                   // [R10]
				end
			end
			DIMF_READY: begin
				if (to_sleep) begin
					next_st.mode = DIMF_SLEEP;                   // [R11]
				end else if (start_req && allowed) begin
					next_st.mode = DIMF_OPER;                    // [R12] [R13]
				end
			end
			DIMF_OPER: begin
				if (stop_req) begin
					next_st.mode = DIMF_READY;                   // [R14]
				end
			end
			default: begin
				next_st.mode = DIMF_SLEEP;                       // [R5]
			end
		endcase

		// Spill-warning bit: set by write, self-clears when start taken or timed out
		if (spill_wr) begin
			next_st.spill     = 1'b1;                            // [R1]
			next_st.spill_cnt = SPILL_LEN[7:0];
		end else if (st.spill) begin
			if (st.mode == DIMF_OPER || st.spill_cnt == 8'h00) begin
				next_st.spill = 1'b0;                            // [R1]
			end else begin
				next_st.spill_cnt = st.spill_cnt - 8'h01;
			end
		end

		// Block transfer acceptance; busy refuses before anything else
		if (blk_valid) begin
			if (busy) begin
				next_st.busy_rej = 1'b1;                         // [R16]
			end else begin
				case (kind)
					DIMF_ADDR_CMD: begin
						next_st.cmd_exec = 1'b1;                 // [R2]
						next_st.cmd_addr = blk_addr;
					end
					DIMF_ADDR_SLAB: begin
						// Config loading is barred while taking data
						if (st.mode == DIMF_OPER) begin
							next_st.refused = 1'b1;              // [R8]
						end else if (blk_write) begin
							next_st.cfg_wr   = 1'b1;             // [R6] [R7]
							next_st.cfg_slab = dec_slab;
							next_st.cfg_alt  = dec_alt;
							next_st.cfg_word = dec_word;
							next_st.cfg_data = blk_data;
						end
					end
					default: begin
						next_st.unknown = 1'b1;                  // [R17]
					end
				endcase
			end
		end
	end

	// Single register bank for the whole controller
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st           <= '0;
			st.mode      <= DIMF_SLEEP;                          // [R18]
			st.cmd_addr  <= 16'h0000;
		end else begin
			st <= next_st;
		end
	end

	assign mode                  = st.mode;
	assign spill_warning_control = st.spill;
	// Chip-side sub-machines take this as a level and sequence on their own
	assign detector_power        = (st.mode != DIMF_SLEEP);          // [R6]
	assign chip_autonomous       = (st.mode == DIMF_OPER);            // [R9] [R15]
	assign cfg_wr                = st.cfg_wr;
	assign cfg_slab              = st.cfg_slab;
	assign cfg_alt               = st.cfg_alt;
	assign cfg_word              = st.cfg_word;
	assign cfg_data              = st.cfg_data;
	assign cmd_exec              = st.cmd_exec;
	assign cmd_addr              = st.cmd_addr;
	assign busy_reject_flag      = st.busy_rej;
	assign unknown_flag          = st.unknown;
	assign refused_flag          = st.refused;

	sequence s_ready_start;
		st.mode == DIMF_READY && !to_sleep && start_req;
	endsequence

	chk_start_allowed: assert property (@(posedge clk_sys) disable iff (reset) // [R12]
		(s_ready_start and allowed) |=> mode == DIMF_OPER)
		else $error("permitted start did not enter operating");
	chk_start_blocked: assert property (@(posedge clk_sys) disable iff (reset) // [R12]
		(s_ready_start and !allowed) |=> mode == DIMF_READY)
		else $error("start without config changed mode");
	chk_stop_ready: assert property (@(posedge clk_sys) disable iff (reset) // [R14]
		mode == DIMF_OPER && stop_req |=> mode == DIMF_READY)
		else $error("stop condition did not return to ready");
	chk_sleep_wake: assert property (@(posedge clk_sys) disable iff (reset) // [R10]
		mode == DIMF_SLEEP && to_ready |=> mode == DIMF_READY)
		else $error("wake trigger ignored in sleep");
	chk_sleep_hold: assert property (@(posedge clk_sys) disable iff (reset) // [R18]
		mode == DIMF_SLEEP && !to_ready |=> mode == DIMF_SLEEP)
		else $error("sleep left without trigger");
	chk_ready_sleep: assert property (@(posedge clk_sys) disable iff (reset) // [R11]
		mode == DIMF_READY && to_sleep |=> mode == DIMF_SLEEP)
		else $error("sleep trigger ignored in ready");
	chk_busy_refuse: assert property (@(posedge clk_sys) disable iff (reset) // [R16]
		blk_valid && busy |=> busy_reject_flag && !cmd_exec && !cfg_wr)
		else $error("busy command not refused");
	chk_oper_nocfg: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
		mode == DIMF_OPER && blk_valid && kind == DIMF_ADDR_SLAB |=> !cfg_wr && refused_flag)
		else $error("config load accepted while operating");
	chk_unknown_addr: assert property (@(posedge clk_sys) disable iff (reset) // [R17]
		blk_valid && !busy && blk_addr > CMD_LAST && blk_addr < SLAB_BASE
		|=> unknown_flag && !cfg_wr)
		else $error("unmapped address not flagged");
	chk_spill_set: assert property (@(posedge clk_sys) disable iff (reset) // [R1]
		spill_wr |=> spill_warning_control)
		else $error("spill warning write did not set bit");
	chk_mode_legal: assert property (@(posedge clk_sys) disable iff (reset) // [R5]
		mode inside {DIMF_SLEEP, DIMF_READY, DIMF_OPER})
		else $error("illegal mode encoding");
endmodule

// ===== logic/dimf_pkg.sv
/*
 * Shared constants and carriers for the detector interface mode controller:
 * command address windows, mode encoding, decoded command record.
 * Assumes one clock domain and decoded command strobes from the link front end.
 */
// Operation
// R1: Writing 0x0001 to spill-warning register arms device; device clears bit when done.
// R2: Addresses 0x0000 through 0x0090 decode as block transfer commands.
// R3: Default config sets at 0x1000, 0x3000, 0x5000, 0x7000, 4K words each.
// R4: Alternative config sets at 0x2000, 0x4000, 0x6000, 0x8000, 4K words each.
// R5: Top controller has exactly three states: sleep, ready, operating.
// R6: Sleep keeps link, register access and config loading alive, detector unpowered.
// R7: Ready allows everything; measurement starts only if configured and error free.
// R8: Operating refuses config loading and debug commands.
// R9: Operating lets chip-side logic run autonomously and generate triggers.
// R10: Sleep to ready on power-on, async spill warning, mode select, pulsed supply.
// R11: Back to sleep on regulators-off power-on, mode select, pulsed supply.
// R12: Ready to operating only when configured and no error; else no change.
// R13: Ready to operating on acquisition start, sync spill warning, results fetch.
// R14: Operating to ready on stop, buffer full, saturation, readout done, reset.
// R15: Chip-side sub-machines run independently of the top controller.
// R16: Command arriving while busy is refused and raises busy-reject flag.
// R17: Unmapped address is unknown command and changes no stored configuration.
// R18: After reset enter sleep and hold until a sleep-to-ready trigger.
package dimf_pkg;
	localparam logic [15:0] CMD_LAST      = 16'h0090;
	localparam logic [15:0] SPILL_ADDR    = 16'h001c;
	localparam logic [15:0] SPILL_SET_VAL = 16'h0001;
	localparam logic [15:0] SLAB_BASE     = 16'h1000;
	localparam logic [15:0] SLAB_LAST     = 16'h8fff;
	localparam logic [15:0] SPILL_RESET   = 16'h0000;
	localparam int          SPILL_HOLD_NS = 100;
	localparam int          CLK_NS        = 4;
	localparam int          SPILL_CYCLES  = (SPILL_HOLD_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		DIMF_SLEEP,
		DIMF_READY,
		DIMF_OPER
	} dimf_mode_t;

	typedef enum logic [1:0] {
		DIMF_ADDR_CMD,
		DIMF_ADDR_SLAB,
		DIMF_ADDR_UNKNOWN
	} dimf_addr_t;

	// Decoded command strobes, one cycle each
	typedef struct packed {
		logic power_on;
		logic regs_off;
		logic mode_select_cmd;
		logic pulse_dbg;
		logic acq_start;
		logic acq_stop;
		logic results_fetch;
		logic reset_cmd;
	} dimf_cmd_t;

	// Chip-side conditions, levels
	typedef struct packed {
		logic config_done;
		logic error_pending;
		logic buffer_full_flag;
		logic analog_memory_saturated;
		logic readout_done;
	} dimf_cond_t;
endpackage
